// *** hw/uctl_top.sv ***
// Control register, status flags, interrupt and baud tick of the serial block
`timescale 1ns/1ns
module uctl_top #(
   parameter bit HAS_FLOW_CTRL = 1'b1,
   parameter bit HAS_SW_BAUD = 1'b1,
   parameter bit HAS_EOP_REG = 1'b1,
   parameter bit HAS_PARITY = 1'b1,
   parameter int DATA_BITS = 8
) (
   // Clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_RESETN,
   // Register port
   input wire uctl_pkg::uctl_bus_type I_BUS,
   output logic [15:0] O_RDATA,
   // Shift engine side
   input wire uctl_pkg::uctl_event_type I_EVT,
   input wire logic I_TX_SHIFTER_EMPTY,
   input wire logic I_TX_HOLDING_READY,
   input wire logic I_RX_HOLDING_READY,
   input wire logic [7:0] I_RX_DATA,
   input wire logic I_TX_LINE,
   output logic [7:0] O_TX_DATA,
   output logic O_TX_LOAD,
   output logic O_RX_TAKEN,
   output logic O_BAUD_TICK,
   // Serial and modem pins
   input wire logic I_CTS_N,
   output logic O_TXD,
   output logic O_RTS_N,
   // Interrupt
   output logic O_IRQ
);
   // Elaboration check: the character compare serves only 7 or 8 data bits
   if (DATA_BITS < 7 || DATA_BITS > 8) begin : g_bad_width
      $error("DATA_BITS must be 7 or 8");
   end

   typedef struct packed {
      logic [12:0] control;
      logic [15:0] divisor;
      logic [7:0] eop_char;
      logic pe;
      logic fe;
      logic line_break_flag;
      logic rx_overrun_flag;
      logic tx_overrun_flag;
      logic cts_chg;
      logic eop;
      logic cts_s1;
      logic cts_s2;
      logic cts_s3;
      logic [15:0] baud_cnt;
      logic baud_tick;
      logic [15:0] rdata;
      logic [7:0] tx_data;
      logic tx_load;
      logic rx_taken;
   } uctl_state_type;

   uctl_state_type st_reg, st_next;
   logic rst_m_reg, rst_n_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         rst_m_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_m_reg <= 1'b1;
         rst_n_reg <= rst_m_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control mask honouring the flow-control build option
   function automatic logic [12:0] ctl_mask(input bit flow);
      ctl_mask = uctl_pkg::CONTROL_BASE_MASK | (flow ? uctl_pkg::RTS_MASK : 13'h0000);
   endfunction

   // Character comparison, trimmed to the data width
   function automatic logic char_match(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] m;
      m = (DATA_BITS == 8) ? 8'hFF : 8'h7F;
      char_match = ((a ^ b) & m) == 8'h00;
   endfunction

   logic wr_status, wr_control, wr_tx, rd_rx;
   logic exc_flag;
   logic [12:0] status_word;
   logic [15:0] rd_mux;

   // Decoded strobes
   assign wr_status = I_BUS.wr && I_BUS.addr == uctl_pkg::STATUS_IDX;
   assign wr_control = I_BUS.wr && I_BUS.addr == uctl_pkg::CONTROL_IDX;
   assign wr_tx = I_BUS.wr && I_BUS.addr == uctl_pkg::TX_DATA_IDX;
   assign rd_rx = I_BUS.rd && I_BUS.addr == uctl_pkg::RX_DATA_IDX;

   // Exception flag combines all error flags
   assign exc_flag = st_reg.tx_overrun_flag | st_reg.rx_overrun_flag | st_reg.line_break_flag | st_reg.fe | st_reg.pe;

   // Status word as seen by software
   always_comb begin
      status_word = 13'h0000;
      status_word[uctl_pkg::PE_BIT] = st_reg.pe & HAS_PARITY;
      status_word[uctl_pkg::FE_BIT] = st_reg.fe;
      status_word[uctl_pkg::BRK_BIT] = st_reg.line_break_flag;
      status_word[uctl_pkg::ROE_BIT] = st_reg.rx_overrun_flag;
      status_word[uctl_pkg::TOE_BIT] = st_reg.tx_overrun_flag;
      status_word[uctl_pkg::TMT_BIT] = I_TX_SHIFTER_EMPTY;
      status_word[uctl_pkg::TRDY_BIT] = I_TX_HOLDING_READY;
      status_word[uctl_pkg::RRDY_BIT] = I_RX_HOLDING_READY;
      status_word[uctl_pkg::EXC_BIT] = exc_flag;
      status_word[uctl_pkg::CTS_CHG_BIT] = st_reg.cts_chg & HAS_FLOW_CTRL;
      status_word[uctl_pkg::RTS_BIT] = ~st_reg.cts_s2 & HAS_FLOW_CTRL;
      status_word[uctl_pkg::EOP_BIT] = st_reg.eop & HAS_EOP_REG;
   end

   // Read multiplexer; reading status has no side effect
   always_comb begin
      rd_mux = 16'h0000;
      case (I_BUS.addr)
         uctl_pkg::RX_DATA_IDX: rd_mux = {8'h00, I_RX_DATA};
         uctl_pkg::STATUS_IDX: rd_mux = {3'h0, status_word};
         uctl_pkg::CONTROL_IDX: rd_mux = {3'h0, st_reg.control};
         uctl_pkg::DIVISOR_IDX: rd_mux = st_reg.divisor;
         uctl_pkg::EOP_IDX: rd_mux = {8'h00, st_reg.eop_char};
         default: rd_mux = 16'h0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_next = st_reg;
      st_next.tx_load = 1'b0;
      st_next.rx_taken = 1'b0;
      st_next.rdata = I_BUS.rd ? rd_mux : st_reg.rdata;
      // Control write, masked by the flow-control option
      if (wr_control) begin
         st_next.control = I_BUS.wdata[12:0] & ctl_mask(HAS_FLOW_CTRL);
      end
      // Optional divisor and end character
      if (HAS_SW_BAUD && I_BUS.wr && I_BUS.addr == uctl_pkg::DIVISOR_IDX) begin
         st_next.divisor = I_BUS.wdata;
      end
      if (HAS_EOP_REG && I_BUS.wr && I_BUS.addr == uctl_pkg::EOP_IDX) begin
         st_next.eop_char = I_BUS.wdata[7:0];
      end
      // Transmit holding write and receive holding read
      if (wr_tx) begin
         st_next.tx_data = I_BUS.wdata[7:0];
         st_next.tx_load = 1'b1;
      end
      st_next.rx_taken = rd_rx;
      // Clear-to-send synchroniser and edge detect
      st_next.cts_s1 = I_CTS_N;
      st_next.cts_s2 = st_reg.cts_s1;
      st_next.cts_s3 = st_reg.cts_s2;
      // Acknowledge clears sticky flags; new events win below
      if (wr_status) begin
         st_next.pe = 1'b0;
         st_next.fe = 1'b0;
         st_next.line_break_flag = 1'b0;
         st_next.rx_overrun_flag = 1'b0;
         st_next.tx_overrun_flag = 1'b0;
         st_next.cts_chg = 1'b0;
         st_next.eop = 1'b0;
      end
      // Sticky flags set by events
      if (I_EVT.parity_err && HAS_PARITY) st_next.pe = 1'b1;
      if (I_EVT.framing_err) st_next.fe = 1'b1;
      if (I_EVT.line_break) st_next.line_break_flag = 1'b1;
      if (I_EVT.rx_overrun) st_next.rx_overrun_flag = 1'b1;
      if (I_EVT.tx_overrun) st_next.tx_overrun_flag = 1'b1;
      if (HAS_FLOW_CTRL && st_reg.cts_s2 != st_reg.cts_s3) begin
         st_next.cts_chg = 1'b1;
      end
      if (HAS_EOP_REG && ((wr_tx && char_match(I_BUS.wdata[7:0], st_reg.eop_char))
            || (rd_rx && char_match(I_RX_DATA, st_reg.eop_char)))) begin
         st_next.eop = 1'b1;
      end
      // Baud tick every divisor plus one cycles
      st_next.baud_tick = 1'b0;
      if (st_reg.baud_cnt >= st_reg.divisor) begin
         st_next.baud_cnt = 16'h0000;
         st_next.baud_tick = 1'b1;
      end else begin
         st_next.baud_cnt = st_reg.baud_cnt + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge I_SYS_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         st_reg <= '0;
         st_reg.control <= uctl_pkg::CONTROL_RESET;
         st_reg.divisor <= uctl_pkg::DIVISOR_RESET;
         st_reg.eop_char <= uctl_pkg::EOP_CHAR_RESET;
         st_reg.cts_s1 <= 1'b1;
         st_reg.cts_s2 <= 1'b1;
         st_reg.cts_s3 <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   logic [12:0] irq_src;
   always_comb begin
      irq_src = status_word & st_reg.control;
      irq_src[uctl_pkg::BREAK_FORCE_BIT] = 1'b0;
      irq_src[uctl_pkg::RTS_BIT] = 1'b0;
   end
   assign O_IRQ = |irq_src;
   assign O_TXD = st_reg.control[uctl_pkg::BREAK_FORCE_BIT] ? 1'b0 : I_TX_LINE;
   assign O_RTS_N = ~st_reg.control[uctl_pkg::RTS_BIT];
   assign O_RDATA = st_reg.rdata;
   assign O_TX_DATA = st_reg.tx_data;
   assign O_TX_LOAD = st_reg.tx_load;
   assign O_RX_TAKEN = st_reg.rx_taken;
   assign O_BAUD_TICK = st_reg.baud_tick;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   // Break forcing overrides the transmitter level
   a_break_forces_low: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      st_reg.control[uctl_pkg::BREAK_FORCE_BIT] |-> !O_TXD)
      else $error("break not low");
   a_rts_follows_bit: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      wr_control |=> O_RTS_N == !($past(I_BUS.wdata[11]) && HAS_FLOW_CTRL))
      else $error("rts output wrong");
   a_rts_absent: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      !HAS_FLOW_CTRL |-> !st_reg.control[uctl_pkg::RTS_BIT] && O_RTS_N)
      else $error("rts set without flow control");
   // Control register contents as written and as read back
   a_ctl_write_back: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      wr_control |=> st_reg.control[8:0] == $past(I_BUS.wdata[8:0]))
      else $error("enables not stored");
   a_ctl_unused_zero: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      $past(I_BUS.rd && I_BUS.addr == uctl_pkg::CONTROL_IDX) |->
      O_RDATA[15:13] == 3'h0 && (HAS_FLOW_CTRL || !O_RDATA[uctl_pkg::RTS_BIT]))
      else $error("unused bits set");
   a_rdata_holds: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      !I_BUS.rd |=> $stable(O_RDATA))
      else $error("read data moved");
   // Absent options keep their registers at the reset value
   a_divisor_absent: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      !HAS_SW_BAUD |-> st_reg.divisor == uctl_pkg::DIVISOR_RESET)
      else $error("absent divisor written");
   a_eop_absent: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      !HAS_EOP_REG |-> st_reg.eop_char == uctl_pkg::EOP_CHAR_RESET)
      else $error("absent end character written");
   // Interrupt request against flags and enables
   a_irq_needs_enable: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      st_reg.control == 13'h0000 |-> !O_IRQ)
      else $error("irq without enable");
   a_irq_on_flag: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      st_reg.control[uctl_pkg::FE_BIT] && st_reg.fe |-> O_IRQ)
      else $error("irq missing");
   // Sticky flags: set by events, kept on reads, cleared by status writes
   a_flag_sticky: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      st_reg.fe && !wr_status |=> st_reg.fe)
      else $error("flag dropped");
   a_status_read_keeps: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      I_BUS.rd && !I_BUS.wr && st_reg.pe |=> st_reg.pe)
      else $error("read cleared a flag");
   a_ack_clears: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      wr_status && !I_EVT.line_break |=> !st_reg.line_break_flag)
      else $error("ack failed");
   a_set_beats_clear: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      wr_status && I_EVT.tx_overrun |=> st_reg.tx_overrun_flag)
      else $error("event lost");
   a_exc_is_or: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      st_reg.rx_overrun_flag |-> status_word[uctl_pkg::EXC_BIT])
      else $error("exception not set");
   a_exc_clear: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      !st_reg.pe && !st_reg.fe && !st_reg.line_break_flag && !st_reg.rx_overrun_flag && !st_reg.tx_overrun_flag |->
      !status_word[uctl_pkg::EXC_BIT])
      else $error("exception without cause");
   a_cts_edge_flag: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      HAS_FLOW_CTRL && $changed(st_reg.cts_s2) |=> st_reg.cts_chg)
      else $error("cts change missed");
   // Baud tick spacing for a divisor of four
   a_baud_period: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      O_BAUD_TICK && st_reg.divisor == 16'h0004 && $stable(st_reg.divisor) |=>
      (!O_BAUD_TICK) [*4] ##1 O_BAUD_TICK)
      else $error("baud period wrong");
   // End character seen on either holding register
   a_eop_on_write: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      HAS_EOP_REG && wr_tx && I_BUS.wdata[7:0] == st_reg.eop_char |=> st_reg.eop)
      else $error("eop not set");
   a_eop_on_read: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n_reg)
      HAS_EOP_REG && rd_rx && I_RX_DATA == st_reg.eop_char |=> st_reg.eop)
      else $error("eop not set on read");
endmodule // uctl_top

// *** common/uctl_pkg.sv ***
// Package with constants and types for the serial control and interrupt block
package uctl_pkg;
   // Register indices (word address = index)
   localparam logic [2:0] RX_DATA_IDX = 3'h0;
   localparam logic [2:0] TX_DATA_IDX = 3'h1;
   localparam logic [2:0] STATUS_IDX = 3'h2;
   localparam logic [2:0] CONTROL_IDX = 3'h3;
   localparam logic [2:0] DIVISOR_IDX = 3'h4;
   localparam logic [2:0] EOP_IDX = 3'h5;
   // Control and status bit positions
   localparam int PE_BIT = 0;
   localparam int FE_BIT = 1;
   localparam int BRK_BIT = 2;
   localparam int ROE_BIT = 3;
   localparam int TOE_BIT = 4;
   localparam int TMT_BIT = 5;
   localparam int TRDY_BIT = 6;
   localparam int RRDY_BIT = 7;
   localparam int EXC_BIT = 8;
   localparam int BREAK_FORCE_BIT = 9;
   localparam int CTS_CHG_BIT = 10;
   localparam int RTS_BIT = 11;
   localparam int EOP_BIT = 12;
   // Reset values
   localparam logic [12:0] CONTROL_RESET = 13'h0000;
   localparam logic [7:0] EOP_CHAR_RESET = 8'h00;
   localparam logic [15:0] DIVISOR_RESET = 16'h0056;
   // Writable masks of the control register
   localparam logic [12:0] CONTROL_BASE_MASK = 13'h17FF;
   localparam logic [12:0] RTS_MASK = 13'h0800;
   // Events reported by the shift engines, one-cycle pulses
   typedef struct packed {
      logic parity_err;
      logic framing_err;
      logic line_break;
      logic rx_overrun;
      logic tx_overrun;
   } uctl_event_type;
   // Register bus request
   typedef struct packed {
      logic [2:0] addr;
      logic rd;
      logic wr;
      logic [15:0] wdata;
   } uctl_bus_type;
endpackage

// *** bench/uctl_host_model.sv ***
// Bus master model issuing register reads and writes to the block
`timescale 1ns/1ns
module uctl_host_model (
   // Clock
   input wire logic i_clk,
   // Register port
   output uctl_pkg::uctl_bus_type o_bus,
   input wire logic [15:0] i_rdata
);
   initial o_bus = '0;
   // One write strobe; data lines scrambled once released
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(negedge i_clk);
      o_bus.addr = a;
      o_bus.wdata = d;
      o_bus.wr = 1'b1;
      @(negedge i_clk);
      o_bus.wr = 1'b0;
      o_bus.wdata = ~d;
   endtask
   // One read strobe; registered answer taken the cycle after
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(negedge i_clk);
      o_bus.addr = a;
      o_bus.rd = 1'b1;
      @(negedge i_clk);
      o_bus.rd = 1'b0;
      d = i_rdata;
   endtask
endmodule // uctl_host_model

// *** bench/tb.sv ***
// Self-checking bench for the serial control and interrupt block
`timescale 1ns/1ns
module tb;
   localparam logic [2:0] CT = uctl_pkg::CONTROL_IDX;
   localparam logic [2:0] ST = uctl_pkg::STATUS_IDX;
   localparam logic [2:0] EP = uctl_pkg::EOP_IDX;
   logic clk, rst_n, tmt, trdy, rrdy, tx_line, cts_n, txd, rts_n, irq, rts_n_min, tick;
   uctl_pkg::uctl_bus_type bus;
   uctl_pkg::uctl_event_type evt;
   logic [15:0] rdata, rdata_min, d;
   logic [7:0] rx_data, tx_data;
   logic tx_load, rx_taken;
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;
   uctl_host_model i_host (.i_clk(clk), .o_bus(bus), .i_rdata(rdata));
   uctl_top i_dut (.I_SYS_CLK(clk), .I_RESETN(rst_n), .I_BUS(bus), .O_RDATA(rdata),
      .I_EVT(evt), .I_TX_SHIFTER_EMPTY(tmt), .I_TX_HOLDING_READY(trdy),
      .I_RX_HOLDING_READY(rrdy), .I_RX_DATA(rx_data), .I_TX_LINE(tx_line),
      .O_TX_DATA(tx_data), .O_TX_LOAD(tx_load), .O_RX_TAKEN(rx_taken),
      .O_BAUD_TICK(tick), .I_CTS_N(cts_n), .O_TXD(txd),
      .O_RTS_N(rts_n), .O_IRQ(irq));
   // Build with flow control, software baud and end character left out; parity kept
   uctl_top #(.HAS_FLOW_CTRL(1'b0), .HAS_SW_BAUD(1'b0), .HAS_EOP_REG(1'b0)) i_dut_min (
      .I_SYS_CLK(clk), .I_RESETN(rst_n), .I_BUS(bus), .O_RDATA(rdata_min), .I_EVT(evt),
      .I_TX_SHIFTER_EMPTY(tmt), .I_TX_HOLDING_READY(trdy), .I_RX_HOLDING_READY(rrdy),
      .I_RX_DATA(rx_data), .I_TX_LINE(tx_line), .O_TX_DATA(), .O_TX_LOAD(),
      .O_RX_TAKEN(), .O_BAUD_TICK(), .I_CTS_N(cts_n), .O_TXD(), .O_RTS_N(rts_n_min),
      .O_IRQ());
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         results();
      end
   end
   task automatic results();
      if (err_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // Status word expected from sticky flags plus live levels
   function automatic logic [15:0] stat(input logic [15:0] f);
      return f | {4'h0, ~cts_n, 3'h0, rrdy, trdy, tmt, 5'h00};
   endfunction
   task automatic t_reset();
      chk("rts_n", 16'h0001, rts_n);
      chk("irq", 16'h0000, irq);
      i_host.rd(CT, d);
      chk("control", 16'h0000, d);
      i_host.rd(EP, d);
      chk("eop char", 16'h0000, d);
   endtask
   task automatic t_ctrl();
      i_host.wr(CT, 16'hFFFF);
      i_host.rd(CT, d);
      chk("control", 16'h1FFF, d);
      chk("txd", 16'h0000, txd);
      chk("rts_n", 16'h0000, rts_n);
      chk("min control", 16'h17FF, rdata_min);
      chk("min rts_n", 16'h0001, rts_n_min);
      i_host.wr(CT, 16'h0000);
      chk("txd", 16'h0001, txd);
      chk("rts_n", 16'h0001, rts_n);
      tx_line = 1'b0;
      @(negedge clk);
      chk("txd pass", 16'h0000, txd);
      tx_line = 1'b1;
      i_host.rd(3'h7, d);
      chk("unmapped", 16'h0000, d);
   endtask
   task automatic t_evt();
      for (int i = 0; i < 5; i++) begin
         i_host.wr(CT, 16'h141F ^ (16'h0001 << i));
         evt = uctl_pkg::uctl_event_type'(5'h10 >> i);
         @(negedge clk);
         evt = '0;
         chk("irq masked", 16'h0000, irq);
         i_host.wr(CT, 16'h0001 << i);
         chk("irq", 16'h0001, irq);
         repeat (2) begin
            i_host.rd(ST, d);
            chk("status", stat(16'h0100 | (16'h0001 << i)), d);
         end
         i_host.wr(CT, 16'h0100);
         chk("irq any", 16'h0001, irq);
         i_host.wr(ST, 16'h0000);
         chk("irq ack", 16'h0000, irq);
         i_host.rd(ST, d);
         chk("status ack", stat(16'h0000), d);
      end
      // Event in the same cycle as the acknowledge write must survive
      i_host.wr(CT, 16'h0010);
      fork
         i_host.wr(ST, 16'h0000);
         begin
            @(negedge clk);
            evt.tx_overrun = 1'b1;
            @(negedge clk);
            evt = '0;
         end
      join
      chk("irq set wins", 16'h0001, irq);
      i_host.rd(ST, d);
      chk("status set wins", stat(16'h0110), d);
      i_host.wr(ST, 16'h0000);
      chk("irq set wins ack", 16'h0000, irq);
   endtask
   task automatic t_level();
      for (int i = 5; i < 8; i++) begin
         i_host.wr(CT, 16'h0001 << i);
         chk("irq off", 16'h0000, irq);
         {rrdy, trdy, tmt} = 3'h1 << (i - 5);
         @(negedge clk);
         chk("irq level", 16'h0001, irq);
         {rrdy, trdy, tmt} = 3'h0;
      end
   endtask
   task automatic t_cts();
      i_host.wr(CT, 16'h0400);
      for (int k = 0; k < 2; k++) begin
         cts_n = ~cts_n;
         repeat (4) @(negedge clk);
         chk("irq cts", 16'h0001, irq);
         i_host.rd(ST, d);
         chk("status cts", stat(16'h0400), d);
         i_host.wr(ST, 16'h0000);
         chk("irq cts ack", 16'h0000, irq);
      end
   endtask
   task automatic t_eop();
      i_host.wr(EP, 16'h005A);
      i_host.rd(EP, d);
      chk("eop char", 16'h005A, d);
      i_host.wr(CT, 16'h1000);
      i_host.wr(uctl_pkg::TX_DATA_IDX, 16'h005B);
      chk("tx load", 16'h0001, tx_load);
      chk("tx data", 16'h005B, tx_data);
      chk("irq no match", 16'h0000, irq);
      i_host.wr(uctl_pkg::TX_DATA_IDX, 16'h005A);
      chk("irq tx match", 16'h0001, irq);
      i_host.rd(ST, d);
      chk("status eop", stat(16'h1000), d);
      chk("min status", stat(16'h0000), rdata_min);
      i_host.wr(ST, 16'h0000);
      rx_data = 8'h5A;
      i_host.rd(uctl_pkg::RX_DATA_IDX, d);
      chk("irq rx match", 16'h0001, irq);
      chk("rx taken", 16'h0001, rx_taken);
      i_host.wr(ST, 16'h0000);
   endtask
   task automatic t_baud();
      int n;
      i_host.wr(uctl_pkg::DIVISOR_IDX, 16'h0004);
      repeat (10) @(negedge clk);
      for (n = 0; n < 20 && tick !== 1'b1; n++)
         @(negedge clk);
      @(negedge clk);
      for (n = 1; n < 20 && tick !== 1'b1; n++)
         @(negedge clk);
      chk("tick period", 16'h0005, 16'(n));
   endtask
   initial begin
      rst_n = 1'b0;
      evt = '0;
      {rrdy, trdy, tmt} = 3'h0;
      rx_data = 8'h00;
      tx_line = 1'b1;
      cts_n = 1'b1;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      t_reset();
      t_ctrl();
      t_evt();
      t_level();
      t_cts();
      t_eop();
      t_baud();
      results();
   end
endmodule // tb
